// *** rtc_window_pkg.sv ***
package rtc_window_pkg;
  // pointer field position inside both configuration registers
  localparam int PTR_LSB = 8;
  localparam int PTR_MSB = 9;
  // write-enable bit position inside the clock configuration register
  localparam int WREN_BIT = 13;
  // pointer codes
  localparam logic [1:0] PTR_MIN_SEC = 2'h0;
  localparam logic [1:0] PTR_WD_HR = 2'h1;
  localparam logic [1:0] PTR_MON_DAY = 2'h2;
  localparam logic [1:0] PTR_YEAR = 2'h3;
  // reset values
  localparam logic [1:0] PTR_RESET = 2'h0;
  localparam logic [7:0] FIELD_RESET = 8'h00;
  // unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // cycles after the second key during which the set is honoured
  localparam int UNLOCK_WINDOW_CYCLES = 1;
  // unlock detector states
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT_FIRST = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_e;
endpackage

// *** rtc_unlock_detect.sv ***
`timescale 1ns/1ps
module rtc_unlock_detect (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // any bus access other than a key write this cycle, and key register write
  input wire logic anyAccess,
  input wire logic keyWrite,
  input wire logic [7:0] keyData,
  // set allowed this cycle
  output logic unlockOpen
);
  rtc_window_pkg::key_state_e state;
  rtc_window_pkg::key_state_e next_state;
  // a key only counts when nothing else is accessed in the same cycle
  wire firstKey = keyWrite && !anyAccess && (keyData == rtc_window_pkg::KEY_FIRST);
  wire secondKey = keyWrite && !anyAccess && (keyData == rtc_window_pkg::KEY_SECOND);

  // key sequence: any other access aborts it
  always_comb begin
    next_state = rtc_window_pkg::KEY_IDLE;
    case (state)
      rtc_window_pkg::KEY_IDLE: begin
        if (firstKey) next_state = rtc_window_pkg::KEY_GOT_FIRST;
      end
      rtc_window_pkg::KEY_GOT_FIRST: begin
        if (secondKey) next_state = rtc_window_pkg::KEY_ARMED;
        else if (firstKey) next_state = rtc_window_pkg::KEY_GOT_FIRST;
      end
      default: begin
        if (firstKey) next_state = rtc_window_pkg::KEY_GOT_FIRST;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) state <= rtc_window_pkg::KEY_IDLE;
    else state <= next_state;
  end

  // armed lasts exactly one cycle after the second key
  assign unlockOpen = (state == rtc_window_pkg::KEY_ARMED);
endmodule

// *** rtc_pointer_window_access.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - value pointer in clock config bits 9:8 selects value window pair
// - value high-byte write decrements value pointer, holding at 00
// - value map: 00 min/sec, 01 wd/hr, 10 month/day, 11 -/year
// - alarm pointer in alarm config bits 9:8 selects alarm window pair
// - alarm high-byte write decrements alarm pointer, holding at 00
// - alarm map: 00 min/sec, 01 wd/hr, 10 month/day, 11 nothing
// - reading either alarm window byte decrements alarm pointer
// - reading either value byte decrements; low-byte write does not
// - timekeeping writes ignored unless write-enable bit 13 is set
// - write-enable settable only one cycle after 55h then aa keys
module rtc_pointer_window_access (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // clock configuration register access
  input wire logic clkCfgWrite,
  input wire logic [15:0] clkCfgWdata,
  output logic [15:0] clkCfgRdata,
  // alarm configuration register access
  input wire logic alrmCfgWrite,
  input wire logic [15:0] alrmCfgWdata,
  output logic [15:0] alrmCfgRdata,
  // unlock key register
  input wire logic keyWrite,
  input wire logic [7:0] keyData,
  // value window
  input wire logic valRead,
  input wire logic valWriteHigh,
  input wire logic valWriteLow,
  input wire logic [15:0] valWdata,
  output logic [15:0] valRdata,
  // alarm window
  input wire logic alrmRead,
  input wire logic alrmWriteHigh,
  input wire logic alrmWriteLow,
  input wire logic [15:0] alrmWdata,
  output logic [15:0] alrmRdata,
  // state shown to the rest of the clock
  output logic [1:0] valuePtr,
  output logic [1:0] alarmPtr,
  output logic writeEnable
);
  ////////////////////////////////////////////////////////////////////////////
  // storage: index 0 min/sec, 1 wd/hr, 2 month/day, 3 year (time only)
  logic [7:0] timeHigh [0:3];
  logic [7:0] timeLow [0:3];
  logic [7:0] alrmHigh [0:2];
  logic [7:0] alrmLow [0:2];
  wire unlockOpen;
  // accesses other than a key write; any of them breaks the key sequence
  // the key write itself is left out so that a lone key is never its own abort
  // a config write in the armed slot is judged by the lock logic, not here
  wire otherAccess = clkCfgWrite | alrmCfgWrite | valRead | valWriteHigh | valWriteLow
    | alrmRead | alrmWriteHigh | alrmWriteLow;

  // unlock key detector
  rtc_unlock_detect keyDet (
    .ref_clk(ref_clk),
    .rst(rst),
    .anyAccess(otherAccess),
    .keyWrite(keyWrite),
    .keyData(keyData),
    .unlockOpen(unlockOpen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pointer stepping decisions
  // a read of either byte steps, a high-byte write steps, a low-byte write does not
  wire valStep = valRead | valWriteHigh;
  wire alrmStep = alrmRead | alrmWriteHigh;

  // saturating decrement: code 00 is where both pointers come to rest
  wire valAtFloor = (valuePtr == rtc_window_pkg::PTR_MIN_SEC);
  wire alrmAtFloor = (alarmPtr == rtc_window_pkg::PTR_MIN_SEC);
  wire [1:0] next_valuePtr = valAtFloor ? valuePtr : valuePtr - 2'h1;
  wire [1:0] next_alarmPtr = alrmAtFloor ? alarmPtr : alarmPtr - 2'h1;

  // pointer codes carried by the configuration writes
  wire [1:0] cfgValuePtr = clkCfgWdata[rtc_window_pkg::PTR_MSB:rtc_window_pkg::PTR_LSB];
  wire [1:0] cfgAlarmPtr = alrmCfgWdata[rtc_window_pkg::PTR_MSB:rtc_window_pkg::PTR_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // write lock
  // a set needs the unlock slot or an already open lock; a clear always lands
  wire wantSet = clkCfgWdata[rtc_window_pkg::WREN_BIT];
  wire setAllowed = writeEnable | unlockOpen;
  wire next_writeEnable = wantSet & setAllowed;

  // timekeeping writes are dropped while the lock is closed
  wire timeWriteOk = writeEnable;

  // alarm code 11 has no registers behind it
  wire alarmPtrValid = (alarmPtr != rtc_window_pkg::PTR_YEAR);

  ////////////////////////////////////////////////////////////////////////////
  // value pointer: a config write wins over a step in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      valuePtr <= rtc_window_pkg::PTR_RESET;
    end else if (clkCfgWrite) begin
      valuePtr <= cfgValuePtr;
    end else if (valStep) begin
      valuePtr <= next_valuePtr;
    end
  end

  // alarm pointer: a config write wins over a step in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarmPtr <= rtc_window_pkg::PTR_RESET;
    end else if (alrmCfgWrite) begin
      alarmPtr <= cfgAlarmPtr;
    end else if (alrmStep) begin
      alarmPtr <= next_alarmPtr;
    end
  end

  // write enable register, changed only by a clock config write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      writeEnable <= 1'b0;
    end else if (clkCfgWrite) begin
      writeEnable <= next_writeEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time fields, one entry per pointer code
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : gTime
      // entry i is addressed when the value pointer holds its code
      wire hit = (valuePtr == 2'(i)) && timeWriteOk;
      // code 11 has no upper byte, so a high write there stores nothing
      wire loadHigh = hit && valWriteHigh && (i != 3);
      wire loadLow = hit && valWriteLow;

      // upper byte of the entry
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          timeHigh[i] <= rtc_window_pkg::FIELD_RESET;
        end else if (loadHigh) begin
          timeHigh[i] <= valWdata[15:8];
        end
      end

      // lower byte of the entry
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          timeLow[i] <= rtc_window_pkg::FIELD_RESET;
        end else if (loadLow) begin
          timeLow[i] <= valWdata[7:0];
        end
      end
    end

    // alarm fields: code 11 has no storage and takes no writes
    for (i = 0; i < 3; i++) begin : gAlrm
      // alarm registers sit outside the write lock
      wire hit = (alarmPtr == 2'(i));
      wire loadHigh = hit && alrmWriteHigh;
      wire loadLow = hit && alrmWriteLow;

      // upper byte of the entry
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          alrmHigh[i] <= rtc_window_pkg::FIELD_RESET;
        end else if (loadHigh) begin
          alrmHigh[i] <= alrmWdata[15:8];
        end
      end

      // lower byte of the entry
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          alrmLow[i] <= rtc_window_pkg::FIELD_RESET;
        end else if (loadLow) begin
          alrmLow[i] <= alrmWdata[7:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // value window selection: code 11 shows an empty upper byte beside the year
  wire valYear = (valuePtr == rtc_window_pkg::PTR_YEAR);
  wire [7:0] valHighSel = valYear ? 8'h00 : timeHigh[valuePtr];
  wire [7:0] valLowSel = timeLow[valuePtr];

  // alarm window selection: code 11 reads zero in both bytes
  // the index is parked on entry 0 so it never points past the storage
  wire [1:0] alrmIdx = alarmPtrValid ? alarmPtr : rtc_window_pkg::PTR_MIN_SEC;
  wire [7:0] alrmHighSel = alarmPtrValid ? alrmHigh[alrmIdx] : 8'h00;
  wire [7:0] alrmLowSel = alarmPtrValid ? alrmLow[alrmIdx] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // value read data, taken each cycle for the pointer before any step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      valRdata <= 16'h0000;
    end else begin
      valRdata <= {valHighSel, valLowSel};
    end
  end

  // alarm read data, taken each cycle for the pointer before any step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alrmRdata <= 16'h0000;
    end else begin
      alrmRdata <= {alrmHighSel, alrmLowSel};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration readback: unused bits read zero
  assign clkCfgRdata = {2'h0, writeEnable, 3'h0, valuePtr, 8'h00};
  assign alrmCfgRdata = {6'h00, alarmPtr, 8'h00};
endmodule

// *** rtc_pointer_window_access_sva.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// pointer stepping and write lock seen at the ports
module rtc_pointer_window_access_sva (
  // clock and reset
  input wire logic ref_clk, rst,
  // strobes and levels
  input wire logic clkCfgWrite, alrmCfgWrite, keyWrite, valRead, valWriteHigh, valWriteLow,
  input wire logic alrmRead, alrmWriteHigh, alrmWriteLow, writeEnable,
  // data and pointers
  input wire logic [15:0] clkCfgWdata, alrmCfgWdata, clkCfgRdata,
  input wire logic [7:0] keyData,
  input wire logic [1:0] valuePtr, alarmPtr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_VPTR_STEP: assert property ((valRead || (valWriteHigh && writeEnable)) && !clkCfgWrite
    |=> valuePtr == (($past(valuePtr) == 2'h0) ? 2'h0 : $past(valuePtr) - 2'h1)) else $error("value step");
  AST_APTR_STEP: assert property ((alrmRead || alrmWriteHigh) && !alrmCfgWrite
    |=> alarmPtr == (($past(alarmPtr) == 2'h0) ? 2'h0 : $past(alarmPtr) - 2'h1)) else $error("alarm step");
  AST_VPTR_LOW: assert property (valWriteLow && !valRead && !valWriteHigh && !clkCfgWrite
    |=> $stable(valuePtr)) else $error("value low write stepped");
  AST_APTR_LOW: assert property (alrmWriteLow && !alrmRead && !alrmWriteHigh && !alrmCfgWrite
    |=> $stable(alarmPtr)) else $error("alarm low write stepped");
  AST_VPTR_CFG: assert property (clkCfgWrite |=> valuePtr == $past(clkCfgWdata[9:8]))
    else $error("value pointer load");
  AST_APTR_CFG: assert property (alrmCfgWrite |=> alarmPtr == $past(alrmCfgWdata[9:8]))
    else $error("alarm pointer load");
  AST_WREN_SET: assert property ($rose(writeEnable) |-> $past(clkCfgWrite && clkCfgWdata[13])
    && $past(keyWrite && keyData == 8'haa, 2) && $past(keyWrite && keyData == 8'h55, 3))
    else $error("write enable set without keys");
  AST_WREN_CLR: assert property (clkCfgWrite && !clkCfgWdata[13] |=> !writeEnable)
    else $error("write enable not cleared");
  AST_CFG_VIEW: assert property (clkCfgRdata == {2'h0, writeEnable, 3'h0, valuePtr, 8'h00})
    else $error("config readback");
  cover property ($rose(writeEnable));
  cover property (valRead && valuePtr == 2'h0);
  cover property (alrmWriteHigh && alarmPtr == 2'h3);
endmodule

// *** tb_rtc_pointer_window_access.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module tb_rtc_pointer_window_access;
  localparam logic [8:0] CC = 9'h100, AC = 9'h080, KY = 9'h040, VR = 9'h020, VH = 9'h010;
  localparam logic [8:0] VL = 9'h008, AR = 9'h004, AH = 9'h002, AL = 9'h001;
  logic ref_clk = 0, rst = 1, we = 0, writeEnable;
  logic [8:0] s = 9'h000;
  logic [15:0] d = 16'h0000, r, me, clkCfgRdata, alrmCfgRdata, valRdata, alrmRdata;
  logic [1:0] valuePtr, alarmPtr;
  logic [15:0] f[2][4] = '{default: 16'h0000};
  logic [15:0] eq[$];
  int sq[$], n, j, mk, failures = 0, num_checks = 0;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
  // clock
  always #50 ref_clk = ~ref_clk;
  rtc_pointer_window_access rtc_pointer_window_access_i (.ref_clk(ref_clk), .rst(rst),
    .clkCfgWrite(s[8]), .clkCfgWdata(d), .clkCfgRdata(clkCfgRdata), .alrmCfgWrite(s[7]),
    .alrmCfgWdata(d), .alrmCfgRdata(alrmCfgRdata), .keyWrite(s[6]), .keyData(d[7:0]),
    .valRead(s[5]), .valWriteHigh(s[4]), .valWriteLow(s[3]), .valWdata(d), .valRdata(valRdata),
    .alrmRead(s[2]), .alrmWriteHigh(s[1]), .alrmWriteLow(s[0]), .alrmWdata(d),
    .alrmRdata(alrmRdata), .valuePtr(valuePtr), .alarmPtr(alarmPtr), .writeEnable(writeEnable));
  function logic [15:0] obs(int k);
    return k == 0 ? valRdata : k == 1 ? alrmRdata : k == 2 ? clkCfgRdata : k == 3 ? alrmCfgRdata
      : {8'h00, valRdata[7:0]};
  endfunction
  task cyc(logic [8:0] st, logic [15:0] v);
    @(negedge ref_clk);
    s = st;
    d = v;
  endtask
  task chk(int k, logic [15:0] e);
    sq.push_back(k);
    eq.push_back(e);
  endtask
  task pchk(int w, logic [1:0] q);
    chk(w ? 3 : 2, w ? {6'h00, q, 8'h00} : {2'h0, we, 3'h0, q, 8'h00});
  endtask
  task end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // monitor: notes queued before an edge are compared at the following falling edge
  always @(posedge ref_clk) begin
    n = sq.size();
    @(negedge ref_clk);
    repeat (n) begin
      mk = sq.pop_front();
      me = eq.pop_front();
      `CHK(obs(mk), me)
    end
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    end_sim;
  end
  // stimulus
  initial begin
    void'($urandom(32'h025afcd7));
    repeat (10) @(negedge ref_clk);
    rst = 0;
    pchk(0, 2'h0);
    pchk(1, 2'h0);
    cyc(KY, 16'h0055);
    cyc(VR, 16'h0000);
    cyc(KY, 16'h00aa);
    cyc(CC, 16'h2000);
    pchk(0, 2'h0);
    cyc(KY, 16'h0055);
    cyc(KY, 16'h00aa);
    cyc(CC, 16'h2300);
    we = 1;
    pchk(0, 2'h3);
    $display("unlock test done");
    for (int w = 0; w < 2; w++) begin
      cyc(w ? AC : CC, 16'h2300);
      for (int i = 3; i >= 0; i--) begin
        r = $urandom;
        cyc(w ? AL : VL, r);
        if (w == 0 || i < 3) f[w][i][7:0] = r[7:0];
        pchk(w, i);
        cyc(w ? AH : VH, r);
        if (i < 3) f[w][i][15:8] = r[15:8];
        pchk(w, i == 0 ? 2'h0 : i - 1);
      end
      cyc(w ? AC : CC, 16'h2300);
      for (int k = 0; k < 5; k++) begin
        j = k > 3 ? 0 : 3 - k;
        cyc(w ? AR : VR, 16'h0000);
        if (w == 0) chk(j == 3 ? 4 : 0, j == 3 ? {8'h00, f[0][3][7:0]} : f[0][j]);
        else chk(1, j < 3 ? f[1][j] : 16'h0000);
        pchk(w, j == 0 ? 2'h0 : j - 1);
      end
      $display("window %0d test done", w);
    end
    cyc(CC, 16'h0000);
    we = 0;
    pchk(0, 2'h0);
    cyc(VL, ~f[0][0]);
    cyc(VR, 16'h0000);
    chk(0, f[0][0]);
    repeat (3) @(negedge ref_clk);
    $display("lock test done");
    if (sq.size() != 0) failures++;
    end_sim;
  end
endmodule
bind rtc_pointer_window_access rtc_pointer_window_access_sva rtc_pointer_window_access_sva_i (.*);
